// File: hdl/hbsd_pkg.sv
package hbsd_pkg;
    // Status code order: {shutdown_n, fault_code_bit1_n, fault_code_bit0_n}
    localparam logic [2:0] HBSD_CODE_ILLEGAL = 3'h0;
    localparam logic [2:0] HBSD_CODE_SHORT   = 3'h1;
    localparam logic [2:0] HBSD_CODE_OVERTMP = 3'h2;
    localparam logic [2:0] HBSD_CODE_LOWREG  = 3'h3;
    localparam logic [2:0] HBSD_CODE_WARN    = 3'h6;
    localparam logic [2:0] HBSD_CODE_NORMAL  = 3'h7;

    // Loss-of-toggle timeout on the PWM inputs
    localparam int HBSD_CLK_HZ          = 25_000_000;
    localparam int HBSD_TOGGLE_TMO_US   = 100;
    localparam int HBSD_TOGGLE_TMO_CYC  = HBSD_TOGGLE_TMO_US * (HBSD_CLK_HZ / 1_000_000);
    localparam int HBSD_SYNC_STAGES     = 3;

    typedef enum logic [1:0] {
        HBSD_MODE_POWERDOWN,
        HBSD_MODE_RESET,
        HBSD_MODE_RUN
    } hbsd_mode_t;

    typedef struct packed {
        logic plus_in;
        logic minus_in;
    } hbsd_pair_t;

    typedef struct packed {
        logic drive;
        logic oe;
    } hbsd_bridge_t;

    typedef struct packed {
        logic over_current;
        logic over_temp;
        logic low_reg;
        logic temp_warn;
    } hbsd_sense_t;
endpackage

// File: hdl/hbsd_hbridge_state_decoder.sv
`timescale 1ns/100ps
// Summary of operation
// - Power-down low: outputs Hi-Z, shutdown indicator high.
// - Reset low: ignore PWM, outputs low, indicator high.
// - Reset low clears every stored fault.
// - Shutdown indicator high normally, low on fault.
// - Latched shutdown holds until reset asserted.
// - Plus high minus low gives 1, reverse 0.
// - Equal plus and minus: illegal, output 0.
// - Shut down on four fault kinds.
// - Fault: disabled outputs, shutdown indicator low.
// - Low regulator, overtemp, illegal faults drive 0.
// - Over-current fault places outputs Hi-Z.
// - Positive terminal from A, negative from B.
// - Lost PWM toggling counts as illegal input.
// - Only over-current latches; others self-clear.
// - Three-bit status code on indicator pins.
// - Power-down releases all indicator pins high.
module hbsd_hbridge_state_decoder
    import hbsd_pkg::*;
#(
    parameter int TOGGLE_TMO_CYC = HBSD_TOGGLE_TMO_CYC,
    parameter int CNT_W          = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        power_down_n_i,
    input  wire logic        reset_n_i,
    input  wire hbsd_pair_t  side_a_i,
    input  wire hbsd_pair_t  side_b_i,
    input  wire hbsd_sense_t sense_i,
    output hbsd_bridge_t     bridge_pos_out_o,
    output hbsd_bridge_t     bridge_neg_out_o,
    output logic             shutdown_n_o,
    output logic             shutdown_n_oe_o,
    output logic             fault_code_bit1_n_o,
    output logic             fault_code_bit1_n_oe_o,
    output logic             fault_code_bit0_n_o,
    output logic             fault_code_bit0_n_oe_o
);

    initial begin
        if (TOGGLE_TMO_CYC < 2 || TOGGLE_TMO_CYC >= (1 << CNT_W))
            $error("TOGGLE_TMO_CYC does not fit CNT_W");
    end

    localparam int NIN = 6 + 4;

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] in_q;
        logic [CNT_W-1:0] tmo_a;
        logic [CNT_W-1:0] tmo_b;
        logic           oc_latch;
        hbsd_bridge_t   pos;
        hbsd_bridge_t   neg;
        logic [2:0]     code;
        logic           ind_oe;
    } hbsd_state_t;

    hbsd_state_t st;
    hbsd_state_t next_st;

    function automatic logic pair_illegal(input hbsd_pair_t p);
        return p.plus_in == p.minus_in;
    endfunction

    function automatic logic [CNT_W-1:0] tmo_step(input logic [CNT_W-1:0] c,
                                                  input logic toggled);
        if (toggled)
            return '0;
        else if (c < CNT_W'(TOGGLE_TMO_CYC))
            return c + CNT_W'(1);
        else
            return c;
    endfunction

    logic [NIN-1:0] raw;
    hbsd_pair_t     pa;
    hbsd_pair_t     pb;
    logic           pwr_n;
    logic           rst_n;
    hbsd_sense_t    sn;
    logic           illegal;
    logic           lost_a;
    logic           lost_b;
    hbsd_mode_t     mode;

    assign raw = {power_down_n_i, reset_n_i, side_a_i, side_b_i, sense_i};

    always_comb begin
        next_st = st;
        // Three-stage sampling; accept change once stages two and three agree
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < NIN; i++) begin
            if (st.s2[i] == st.s3[i])
                next_st.in_q[i] = st.s3[i];
        end
        {pwr_n, rst_n, pa, pb, sn} = st.in_q;

        if (!pwr_n)
            mode = HBSD_MODE_POWERDOWN;
        else if (!rst_n)
            mode = HBSD_MODE_RESET;
        else
            mode = HBSD_MODE_RUN;

        // Loss-of-toggle watchdog per side
        next_st.tmo_a = tmo_step(st.tmo_a, next_st.in_q[7] != st.in_q[7]);
        next_st.tmo_b = tmo_step(st.tmo_b, next_st.in_q[5] != st.in_q[5]);
        if (mode != HBSD_MODE_RUN) begin
            next_st.tmo_a = '0;
            next_st.tmo_b = '0;
        end
        lost_a  = st.tmo_a >= CNT_W'(TOGGLE_TMO_CYC);
        lost_b  = st.tmo_b >= CNT_W'(TOGGLE_TMO_CYC);
        illegal = pair_illegal(pa) || pair_illegal(pb) || lost_a || lost_b;

        // Over-current latch, cleared only by reset
        if (mode == HBSD_MODE_RESET)
            next_st.oc_latch = 1'b0;
        else if (mode == HBSD_MODE_RUN && sn.over_current)
            next_st.oc_latch = 1'b1;

        next_st.ind_oe = 1'b1;
        unique case (mode)
            HBSD_MODE_POWERDOWN: begin
                next_st.pos    = '{drive: 1'b0, oe: 1'b0};
                next_st.neg    = '{drive: 1'b0, oe: 1'b0};
                next_st.code   = HBSD_CODE_NORMAL;
                next_st.ind_oe = 1'b0;
            end
            HBSD_MODE_RESET: begin
                next_st.pos  = '{drive: 1'b0, oe: 1'b1};
                next_st.neg  = '{drive: 1'b0, oe: 1'b1};
                next_st.code = HBSD_CODE_NORMAL;
            end
            HBSD_MODE_RUN: begin
                // Positive from side A, negative from side B
                next_st.pos  = '{drive: pa.plus_in && !pa.minus_in, oe: 1'b1};
                next_st.neg  = '{drive: pb.plus_in && !pb.minus_in, oe: 1'b1};
                next_st.code = sn.temp_warn ? HBSD_CODE_WARN : HBSD_CODE_NORMAL;
                // Fault priority; over-current first since it latches
                if (sn.over_current || st.oc_latch) begin
                    next_st.pos  = '{drive: 1'b0, oe: 1'b0};
                    next_st.neg  = '{drive: 1'b0, oe: 1'b0};
                    next_st.code = HBSD_CODE_SHORT;
                end else if (sn.low_reg || sn.over_temp || illegal) begin
                    next_st.pos = '{drive: 1'b0, oe: 1'b1};
                    next_st.neg = '{drive: 1'b0, oe: 1'b1};
                    if (sn.low_reg)
                        next_st.code = HBSD_CODE_LOWREG;
                    else if (sn.over_temp)
                        next_st.code = HBSD_CODE_OVERTMP;
                    else
                        next_st.code = HBSD_CODE_ILLEGAL;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st        <= '0;
            st.code   <= HBSD_CODE_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    assign bridge_pos_out_o       = st.pos;
    assign bridge_neg_out_o       = st.neg;
    // Open-drain indicators: drive only a low; high comes from the pull-up
    assign shutdown_n_o           = 1'b0;
    assign fault_code_bit1_n_o    = 1'b0;
    assign fault_code_bit0_n_o    = 1'b0;
    assign shutdown_n_oe_o        = st.ind_oe && !st.code[2];
    assign fault_code_bit1_n_oe_o = st.ind_oe && !st.code[1];
    assign fault_code_bit0_n_oe_o = st.ind_oe && !st.code[0];

endmodule

// File: dv/hbsd_monitor.sv
`timescale 1ns/100ps
module hbsd_monitor
    import hbsd_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         power_down_n_i,
    input wire logic         reset_n_i,
    input wire hbsd_pair_t   side_a_i,
    input wire hbsd_pair_t   side_b_i,
    input wire hbsd_sense_t  sense_i,
    input wire hbsd_bridge_t bridge_pos_out_o,
    input wire hbsd_bridge_t bridge_neg_out_o,
    input wire logic         shutdown_n_oe_o,
    input wire logic         fault_code_bit1_n_oe_o,
    input wire logic         fault_code_bit0_n_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] pos, neg;
    logic [2:0] oes;
    assign pos = bridge_pos_out_o;
    assign neg = bridge_neg_out_o;
    assign oes = {shutdown_n_oe_o, fault_code_bit1_n_oe_o, fault_code_bit0_n_oe_o};
    sequence s_run;
        (power_down_n_i && reset_n_i && $stable(sense_i))[*8];
    endsequence
    property p_pdown; (!power_down_n_i)[*8] |-> !pos[0] && !neg[0] && oes == 3'h0; endproperty
    a_pdown: assert property (p_pdown) else $error("power down state wrong");
    property p_mute; (power_down_n_i && !reset_n_i)[*8] |-> pos == 2'h1 && oes == 3'h0; endproperty
    a_mute: assert property (p_mute) else $error("mute state wrong");
    property p_norm;
        (power_down_n_i && reset_n_i && $stable({side_a_i, side_b_i, sense_i}))[*8]
        ##0 (sense_i == 4'h0 && oes == 3'h0)
        |-> pos == {side_a_i.plus_in, 1'b1} && neg == {side_b_i.plus_in, 1'b1}; endproperty
    a_norm: assert property (p_norm) else $error("decode wrong");
    property p_bad; (power_down_n_i && reset_n_i && side_a_i == 2'h3 && sense_i == 4'h0)[*8]
        |-> oes == 3'h7 && pos == 2'h1; endproperty
    a_bad: assert property (p_bad) else $error("equal pair not refused");
    property p_short; s_run ##0 sense_i.over_current |-> !pos[0] && !neg[0] && oes == 3'h6; endproperty
    a_short: assert property (p_short) else $error("short state wrong");
    property p_latch; (power_down_n_i && reset_n_i)[*8] ##0 !pos[0] |=> !pos[0] && oes == 3'h6;
    endproperty
    a_latch: assert property (p_latch) else $error("short latch lost");
    property p_lowreg; s_run ##0 (sense_i == 4'h2 && pos[0]) |-> pos == 2'h1 && oes == 3'h4;
    endproperty
    a_lowreg: assert property (p_lowreg) else $error("low regulator state wrong");
    property p_heat; s_run ##0 (sense_i == 4'h4 && pos[0]) |-> neg == 2'h1 && oes == 3'h5;
    endproperty
    a_heat: assert property (p_heat) else $error("overtemp state wrong");
endmodule
bind hbsd_hbridge_state_decoder hbsd_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .power_down_n_i(power_down_n_i), .reset_n_i(reset_n_i), .side_a_i(side_a_i),
    .side_b_i(side_b_i), .sense_i(sense_i), .bridge_pos_out_o(bridge_pos_out_o),
    .bridge_neg_out_o(bridge_neg_out_o), .shutdown_n_oe_o(shutdown_n_oe_o),
    .fault_code_bit1_n_oe_o(fault_code_bit1_n_oe_o),
    .fault_code_bit0_n_oe_o(fault_code_bit0_n_oe_o));

// File: dv/hbsd_pwm_model.sv
`timescale 1ns/100ps
module hbsd_pwm_model
    import hbsd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] bad_i,
    output hbsd_pair_t      side_a_o,
    output hbsd_pair_t      side_b_o
);
    logic [2:0] cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) cnt <= 3'h0;
        else if (!bad_i[1]) cnt <= cnt + 3'h1;
    end
    // All four inputs always driven, complementary per half except side A, which bad_i[0] forces to both high
    assign side_a_o = bad_i[0] ? 2'h3 : {cnt[2], ~cnt[2]};
    assign side_b_o = {~cnt[2], cnt[2]};
endmodule

// File: dv/hbridge_state_decoder_tb.sv
`timescale 1ns/100ps
module hbridge_state_decoder_tb
    import hbsd_pkg::*;
;
    logic         clk_i = 1'b0, rst_i, pd_n, rst_n, sd_oe, b1_oe, b0_oe;
    logic [1:0]   bad;
    hbsd_sense_t  sense;
    hbsd_pair_t   sa, sb;
    hbsd_bridge_t pos, neg;
    int           failures = 0, check_count = 0;
    always #20 clk_i = ~clk_i;
    hbsd_pwm_model pwm_u (.clk_i(clk_i), .rst_i(rst_i), .bad_i(bad), .side_a_o(sa), .side_b_o(sb));
    hbsd_hbridge_state_decoder #(.TOGGLE_TMO_CYC(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .power_down_n_i(pd_n), .reset_n_i(rst_n), .side_a_i(sa), .side_b_i(sb), .sense_i(sense),
        .bridge_pos_out_o(pos), .bridge_neg_out_o(neg), .shutdown_n_o(), .shutdown_n_oe_o(sd_oe),
        .fault_code_bit1_n_o(), .fault_code_bit1_n_oe_o(b1_oe), .fault_code_bit0_n_o(),
        .fault_code_bit0_n_oe_o(b0_oe));
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input string what, input logic [7:0] v, input int n,
                        input logic [6:0] exp, input logic [6:0] mask);
        logic [6:0] got;
        @(posedge clk_i);
        #1 {pd_n, rst_n, sense, bad} = v;
        repeat (n) @(posedge clk_i);
        #1 got = {pos, neg, sd_oe, b1_oe, b0_oe} & mask;
        if (exp === 7'h7f) exp = {sa.plus_in, 1'b1, sb.plus_in, 4'h8};
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    initial begin
        {rst_i, pd_n, rst_n, sense, bad} = 9'h100;
        repeat (16) @(posedge clk_i);
        #1 rst_i = 1'b0;
        step("pdown", 8'h40, 10, 7'h00, 7'h2f);
        step("mute", 8'h80, 10, 7'h28, 7'h7f);
        step("run", 8'hc0, 10, 7'h28, 7'h2f);
        step("decode", 8'hc2, 6, 7'h7f, 7'h7f);
        step("stall", 8'hc2, 20, 7'h2f, 7'h7f);
        step("resume", 8'hc0, 10, 7'h28, 7'h2f);
        step("equal", 8'hc1, 10, 7'h2f, 7'h7f);
        step("lowreg", 8'hc8, 10, 7'h2c, 7'h7f);
        step("overtemp", 8'hd0, 10, 7'h2d, 7'h7f);
        step("rank", 8'hd8, 10, 7'h2c, 7'h7f);
        step("warn", 8'hc4, 10, 7'h29, 7'h2f);
        step("short", 8'he0, 10, 7'h06, 7'h2f);
        step("held", 8'hc0, 10, 7'h06, 7'h2f);
        step("clear", 8'h80, 10, 7'h28, 7'h7f);
        step("rerun", 8'hc0, 10, 7'h28, 7'h2f);
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        failures++;
        wrap_up;
    end
endmodule
